// ---- pkg/ptdu_pkg.sv ----
// Constants and carrier types for the transfer buffer RAM block.
// Assumes one 10 MHz clock and a 32-bit AXI4-Lite register slave.
// Operation
// - Toggle bit refreshed on each received packet; a completion in the same cycle writes its own toggle instead
// - List-end flag stops the list
// - One-per-frame bit zero after reset
// - One transaction per frame when flagged
// - Four kbyte shared transfer buffer RAM
// - Iso area ping-pong, ack area single
// - Both iso halves equal, set by length
// - Processor and engine use opposite halves
// - Area lengths writable at any time
// - Each iso half at most 2 kbytes
// - Read-only status shows empty or full
// - Each interrupt source individually maskable
// - PIO or DMA, bursts of 1/4/8
// - Headers and payloads four-byte aligned
// - Engine writes four-bit result code
// - Completion clears the active bit
// - Swap iso halves each frame; both full parks the processor on pong
// - Pointer reaching counter raises end of transfer
package ptdu_pkg;
  localparam int          RAM_BYTES    = 4096;
  localparam int          AW           = 12;
  localparam logic [15:0] ISO_HALF_MAX = 16'h0800;
  localparam int          FRAME_NS     = 1000000;
  localparam int          CLK_NS       = 100;
  localparam int          FRAME_CYC    = FRAME_NS / CLK_NS;
  localparam int          PORT_BYTES   = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_XFER_CNT = 8'h22;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h24;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h25;
  localparam logic [7:0] IDX_ISO_LEN  = 8'h2a;
  localparam logic [7:0] IDX_ACK_LEN  = 8'h2b;
  localparam logic [7:0] IDX_BUF_STAT = 8'h2c;
  localparam logic [7:0] IDX_DMA_CFG  = 8'h2d;
  localparam logic [7:0] IDX_ISO_PORT = 8'h40;
  localparam logic [7:0] IDX_ACK_PORT = 8'h41;

  localparam int ST_PING_FULL = 0;
  localparam int ST_PONG_FULL = 1;
  localparam int ST_ACK_FULL  = 2;
  localparam int ST_PING_DONE = 3;
  localparam int ST_PONG_DONE = 4;
  localparam int ST_ACK_DONE  = 5;

  localparam int IRQ_ISO = 0;
  localparam int IRQ_ACK = 1;
  localparam int IRQ_EOT = 2;
  localparam int IRQ_W   = 3;

  localparam int HDR_ACTIVE_BIT = 3;
  localparam int HDR_TOGGLE_BIT = 2;

  localparam logic [3:0] RC_NO_ERROR = 4'h0;
  localparam logic [3:0] RC_CRC      = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [15:0] RST_LEN  = 16'h0000;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    DIR_SETUP = 2'b00,
    DIR_OUT   = 2'b01,
    DIR_IN    = 2'b10,
    DIR_RSVD  = 2'b11
  } ptdu_dir_t;

  typedef enum logic [1:0] {
    BURST_SINGLE = 2'b00,
    BURST_4      = 2'b01,
    BURST_8      = 2'b10,
    BURST_1      = 2'b11
  } ptdu_burst_t;

  // Eight header bytes, byte 0 in the low bits
  typedef struct packed {
    logic [7:0] rsvd7;
    logic       iso_format;
    logic [6:0] device_usb_address;
    logic [1:0] rsvd5_hi;
    logic       one_per_frame_bit;
    logic       rsvd5_lo;
    ptdu_dir_t  token_direction;
    logic [1:0] total_byte_count_hi;
    logic [7:0] total_byte_count_lo;
    logic [3:0] endpoint_index;
    logic       list_end;
    logic       low_speed;
    logic [1:0] max_packet_bytes_hi;
    logic [7:0] max_packet_bytes_lo;
    logic [3:0] result_code;
    logic       active;
    logic       toggle;
    logic [1:0] actual_bytes_hi;
    logic [7:0] actual_bytes_lo;
  } ptdu_hdr_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] result_code;
    logic       toggle;
    logic [9:0] actual_bytes;
  } ptdu_done_t;
endpackage : ptdu_pkg

// ---- core/ptdu_iso_pingpong.sv ----
// Ping-pong owner and fill flags of the two isochronous halves.
// Assumes one-cycle event pulses from the core on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ptdu_iso_pingpong
  import ptdu_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sof,
  input  wire logic       cpu_wr_end,
  input  wire logic       cpu_rd_end,
  input  wire logic       eng_done,
  output logic            cpu_half_q,
  output logic [1:0]      full_q,
  output logic [1:0]      done_q
);
  // Half 0 is ping, half 1 is pong
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_half_q <= 1'b0;
    end else if (sof) begin
      // Both halves full: processor moves to or stays on pong
      if (&full_q) begin
        cpu_half_q <= 1'b1;
      end else begin
        cpu_half_q <= ~cpu_half_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_q <= 2'b00;
      done_q <= 2'b00;
    end else begin
      if (cpu_rd_end) begin
        full_q[cpu_half_q] <= 1'b0;
        done_q[cpu_half_q] <= 1'b0;
      end
      // Sets come last so an event in the clearing cycle is kept
      if (cpu_wr_end) begin
        full_q[cpu_half_q] <= 1'b1;
      end
      if (eng_done) begin
        done_q[~cpu_half_q] <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_swap_each_frame: assert property (sof && !(&full_q) |=> cpu_half_q != $past(cpu_half_q))
    else $error("iso halves not swapped at frame start");
  a_no_swap_full: assert property (sof && (&full_q) |=> cpu_half_q)
    else $error("processor not parked on pong with both halves full");
  c_both_full: cover property (sof && (&full_q));
endmodule : ptdu_iso_pingpong
`default_nettype wire

// ---- core/ptdu_desc_update.sv ----
// Header byte rewrite for packet reception and descriptor completion.
// Assumes the core supplies the current byte 1 of the header.
`timescale 1ns/1ns
`default_nettype none
module ptdu_desc_update
  import ptdu_pkg::*;
(
  input  wire logic       rx_pkt,
  input  wire logic       rx_toggle,
  input  wire ptdu_done_t done,
  input  wire logic [7:0] old_b1,
  output logic            we_b0,
  output logic            we_b1,
  output logic [7:0]      new_b0,
  output logic [7:0]      new_b1
);
  always_comb begin
    we_b0  = 1'b0;
    we_b1  = 1'b0;
    new_b0 = done.actual_bytes[7:0];
    new_b1 = old_b1;
    if (done.valid) begin
      we_b0  = 1'b1;
      we_b1  = 1'b1;
      // Completion carries its own toggle and always drops active
      new_b1 = {done.result_code, 1'b0, done.toggle, done.actual_bytes[9:8]};
    end else if (rx_pkt) begin
      we_b1  = 1'b1;
      new_b1[HDR_TOGGLE_BIT] = rx_toggle;
    end
  end
endmodule : ptdu_desc_update
`default_nettype wire

// ---- core/ptdu_buffer_core.sv ----
// Transfer buffer RAM with ack and iso areas, AXI4-Lite registers and engine port.
// Assumes the host engine runs on aclk and drives one-cycle pulses.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ptdu_buffer_core
  import ptdu_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [11:0]      s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  input  wire logic             eng_area_iso,
  input  wire logic [AW-1:0]    eng_addr,
  input  wire logic             eng_wr,
  input  wire logic [7:0]       eng_wdata,
  output logic [7:0]            eng_rdata_q,
  input  wire logic [AW-1:0]    eng_desc_addr,
  output ptdu_hdr_t             eng_hdr_q,
  output logic                  eng_list_end,
  input  wire logic             eng_rx_pkt,
  input  wire logic             eng_rx_toggle,
  input  wire ptdu_done_t       eng_done,
  input  wire logic             eng_list_done,
  input  wire logic             eng_issue_req,
  output logic                  eng_issue_ok,
  output logic                  sof_q,
  output logic                  transfer_end_signal_q,
  output logic                  irq,
  output logic                  dma_req_q
);
  localparam int FW = $clog2(FRAME_CYCLES + 1);

  logic [7:0]       mem_q [RAM_BYTES];
  logic [FW-1:0]    frame_cnt_q;
  logic [15:0]      iso_area_length_q;
  logic [15:0]      ack_area_length_q;
  logic [15:0]      xfer_cnt_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] cpu_irq_mask_q;
  logic [2:0]       dma_cfg_q;
  logic [3:0]       burst_cnt_q;
  logic [AW:0]      cpu_ptr_q;
  logic             xfer_act_q;
  logic             ack_full_q;
  logic             ack_done_q;
  logic             opf_used_q;
  logic             aw_have_q;
  logic             w_have_q;
  logic [7:0]       aw_idx_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;
  logic             cpu_half_q;
  logic [1:0]       iso_full_q;
  logic [1:0]       iso_done_q;
  logic [15:0]      iso_eff;
  logic             wr_fire;
  logic             rd_fire;
  logic [7:0]       ar_idx;
  logic             port_wr;
  logic             port_rd;
  logic             acc_iso;
  logic             transfer_end_signal;
  logic [AW-1:0]    cpu_addr;
  logic [AW-1:0]    eng_phys;
  logic [AW-1:0]    hdr_addr;
  logic             upd_we0;
  logic             upd_we1;
  logic [7:0]       upd_b0;
  logic [7:0]       upd_b1;
  logic [63:0]      hdr_vec;
  logic [31:0]      rd_word;
  logic [31:0]      reg_rd;
  logic             reg_hit;
  logic [3:0]       burst_len;

  // Half size capped so one half never exceeds its limit
  assign iso_eff = (iso_area_length_q > ISO_HALF_MAX) ? ISO_HALF_MAX : iso_area_length_q;

  // Ack area at 0, ping after it, pong after ping; both halves share iso_eff
  function automatic logic [AW-1:0] phys(input logic iso, input logic half,
                                         input logic [AW-1:0] off);
    logic [AW-1:0] base;
    base = '0;
    if (iso) begin
      base = ack_area_length_q[AW-1:0] + (half ? iso_eff[AW-1:0] : '0);
    end
    return base + off;
  endfunction : phys

  // Frame tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt_q <= '0;
      sof_q       <= 1'b0;
    end else begin
      sof_q <= (frame_cnt_q == FW'(FRAME_CYCLES - 1));
      if (frame_cnt_q == FW'(FRAME_CYCLES - 1)) begin
        frame_cnt_q <= '0;
      end else begin
        frame_cnt_q <= frame_cnt_q + 1'b1;
      end
    end
  end

  // AXI4-Lite handshakes; address and data may arrive in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  // A pending write blocks reads so the port pointer moves once per cycle
  assign s_axi_arready = !s_axi_rvalid && !(aw_have_q && w_have_q);
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[9:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  assign port_wr  = wr_fire && (aw_idx_q == IDX_ISO_PORT || aw_idx_q == IDX_ACK_PORT);
  assign port_rd  = rd_fire && (ar_idx == IDX_ISO_PORT || ar_idx == IDX_ACK_PORT);
  assign acc_iso  = port_wr ? (aw_idx_q == IDX_ISO_PORT) : (ar_idx == IDX_ISO_PORT);
  // Process form so a length write alone moves the addresses
  always_comb begin
    cpu_addr = phys(acc_iso, cpu_half_q, cpu_ptr_q[AW-1:0]);
    eng_phys = phys(eng_area_iso, ~cpu_half_q, eng_addr);
    hdr_addr = phys(eng_area_iso, ~cpu_half_q, eng_desc_addr);
  end
  assign transfer_end_signal      = (port_wr || port_rd) && xfer_act_q
                    && ((cpu_ptr_q + (AW+1)'(PORT_BYTES)) >= xfer_cnt_q[AW:0]);

  // Writable registers; lengths take effect immediately
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iso_area_length_q <= RST_LEN;
      ack_area_length_q <= RST_LEN;
      xfer_cnt_q        <= RST_ZERO;
      cpu_irq_mask_q    <= '0;
      dma_cfg_q         <= 3'h0;
    end else if (wr_fire) begin
      unique case (aw_idx_q)
        IDX_ISO_LEN:  iso_area_length_q <= w_data_q[15:0];
        IDX_ACK_LEN:  ack_area_length_q <= w_data_q[15:0];
        IDX_XFER_CNT: xfer_cnt_q        <= w_data_q[15:0];
        IDX_IRQ_MASK: cpu_irq_mask_q    <= w_data_q[IRQ_W-1:0];
        IDX_DMA_CFG:  dma_cfg_q         <= w_data_q[2:0];
        default: ;
      endcase
    end
  end

  // Port pointer restarts whenever a new transfer count is written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_ptr_q  <= '0;
      xfer_act_q <= 1'b0;
    end else if (wr_fire && aw_idx_q == IDX_XFER_CNT) begin
      cpu_ptr_q  <= '0;
      xfer_act_q <= 1'b1;
    end else if (port_wr || port_rd) begin
      cpu_ptr_q <= cpu_ptr_q + (AW+1)'(PORT_BYTES);
      if (transfer_end_signal) begin
        xfer_act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transfer_end_signal_q <= 1'b0;
    end else begin
      transfer_end_signal_q <= transfer_end_signal;
    end
  end

  // Ack area fill state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_full_q <= 1'b0;
      ack_done_q <= 1'b0;
    end else begin
      if (transfer_end_signal && port_rd && !acc_iso) begin
        ack_full_q <= 1'b0;
        ack_done_q <= 1'b0;
      end
      if (transfer_end_signal && port_wr && !acc_iso) begin
        ack_full_q <= 1'b1;
      end
      if (eng_list_done && !eng_area_iso) begin
        ack_done_q <= 1'b1;
      end
    end
  end

  ptdu_iso_pingpong u_pingpong (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sof        (sof_q),
    .cpu_wr_end (transfer_end_signal && port_wr && acc_iso),
    .cpu_rd_end (transfer_end_signal && port_rd && acc_iso),
    .eng_done   (eng_list_done && eng_area_iso),
    .cpu_half_q (cpu_half_q),
    .full_q     (iso_full_q),
    .done_q     (iso_done_q)
  );

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      if (wr_fire && aw_idx_q == IDX_IRQ_STAT) begin
        irq_stat_q <= irq_stat_q & ~w_data_q[IRQ_W-1:0];
      end
      if (transfer_end_signal) begin
        irq_stat_q[IRQ_EOT] <= 1'b1;
      end
      if (eng_list_done) begin
        irq_stat_q[eng_area_iso ? IRQ_ISO : IRQ_ACK] <= 1'b1;
      end
    end
  end
  assign irq = |(irq_stat_q & cpu_irq_mask_q);

  // DMA request drops for one cycle at each burst boundary
  always_comb begin
    unique case (ptdu_burst_t'(dma_cfg_q[2:1]))
      BURST_4: burst_len = 4'd4;
      BURST_8: burst_len = 4'd8;
      BURST_SINGLE, BURST_1: burst_len = 4'd1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_cnt_q <= 4'h0;
      dma_req_q   <= 1'b0;
    end else begin
      if (port_wr || port_rd) begin
        burst_cnt_q <= (burst_cnt_q + 4'd1 >= burst_len) ? 4'h0 : burst_cnt_q + 4'd1;
      end
      dma_req_q <= dma_cfg_q[0] && xfer_act_q && !transfer_end_signal
                   && !((port_wr || port_rd) && burst_cnt_q + 4'd1 >= burst_len);
    end
  end

  ptdu_desc_update u_desc_update (
    .rx_pkt    (eng_rx_pkt),
    .rx_toggle (eng_rx_toggle),
    .done      (eng_done),
    .old_b1    (mem_q[hdr_addr + 12'd1]),
    .we_b0     (upd_we0),
    .we_b1     (upd_we1),
    .new_b0    (upd_b0),
    .new_b1    (upd_b1)
  );

  // Buffer storage; cleared at reset so per-frame flags start at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      if (port_wr) begin
        for (int b = 0; b < PORT_BYTES; b++) begin
          if (w_strb_q[b]) begin
            mem_q[cpu_addr + AW'(b)] <= w_data_q[8*b +: 8];
          end
        end
      end
      if (eng_wr) begin
        mem_q[eng_phys] <= eng_wdata;
      end
      if (upd_we0) begin
        mem_q[hdr_addr] <= upd_b0;
      end
      if (upd_we1) begin
        mem_q[hdr_addr + 12'd1] <= upd_b1;
      end
    end
  end

  always_comb begin
    hdr_vec = '0;
    rd_word = '0;
    for (int k = 0; k < 8; k++) begin
      hdr_vec[8*k +: 8] = mem_q[hdr_addr + AW'(k)];
    end
    for (int k = 0; k < PORT_BYTES; k++) begin
      rd_word[8*k +: 8] = mem_q[cpu_addr + AW'(k)];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eng_hdr_q   <= '0;
      eng_rdata_q <= 8'h00;
    end else begin
      eng_hdr_q   <= ptdu_hdr_t'(hdr_vec);
      eng_rdata_q <= mem_q[eng_phys];
    end
  end
  assign eng_list_end = eng_hdr_q.list_end;

  // One transaction per frame for flagged descriptors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opf_used_q <= 1'b0;
    end else if (eng_issue_req && eng_issue_ok && eng_hdr_q.one_per_frame_bit) begin
      opf_used_q <= 1'b1;
    end else if (sof_q) begin
      opf_used_q <= 1'b0;
    end
  end
  assign eng_issue_ok = !(eng_hdr_q.one_per_frame_bit && opf_used_q);

  // Register read mux; unmapped reads return zero with an error response
  always_comb begin
    reg_hit = 1'b1;
    reg_rd  = 32'h0000_0000;
    unique case (ar_idx)
      IDX_ISO_LEN:  reg_rd[15:0] = iso_area_length_q;
      IDX_ACK_LEN:  reg_rd[15:0] = ack_area_length_q;
      IDX_XFER_CNT: reg_rd[15:0] = xfer_cnt_q;
      IDX_IRQ_STAT: reg_rd[IRQ_W-1:0] = irq_stat_q;
      IDX_IRQ_MASK: reg_rd[IRQ_W-1:0] = cpu_irq_mask_q;
      IDX_DMA_CFG:  reg_rd[2:0] = dma_cfg_q;
      IDX_BUF_STAT: begin
        reg_rd[ST_PING_FULL] = iso_full_q[0];
        reg_rd[ST_PONG_FULL] = iso_full_q[1];
        reg_rd[ST_ACK_FULL]  = ack_full_q;
        reg_rd[ST_PING_DONE] = iso_done_q[0];
        reg_rd[ST_PONG_DONE] = iso_done_q[1];
        reg_rd[ST_ACK_DONE]  = ack_done_q;
      end
      IDX_ISO_PORT, IDX_ACK_PORT: reg_rd = rd_word;
      default: reg_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        unique case (aw_idx_q)
          IDX_ISO_LEN, IDX_ACK_LEN, IDX_XFER_CNT, IDX_IRQ_STAT, IDX_IRQ_MASK,
          IDX_DMA_CFG, IDX_ISO_PORT, IDX_ACK_PORT: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= reg_rd;
        s_axi_rresp  <= reg_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_eot_sets_irq: assert property (transfer_end_signal |=> irq_stat_q[IRQ_EOT] && transfer_end_signal_q)
    else $error("end of transfer did not raise status and pulse");
  a_half_cap: assert property (iso_eff <= ISO_HALF_MAX)
    else $error("iso half exceeds its maximum");
  a_halves_apart: assert property (iso_eff != '0 && eng_area_iso && acc_iso
                                   && eng_addr == cpu_ptr_q[AW-1:0] |-> eng_phys != cpu_addr)
    else $error("processor and engine share an iso half");
  a_opf_gate: assert property (opf_used_q && eng_hdr_q.one_per_frame_bit |-> !eng_issue_ok)
    else $error("second transaction allowed in one frame");
  a_active_clear: assert property (eng_done.valid && !eng_wr
                                   |=> !mem_q[$past(hdr_addr) + 12'd1][HDR_ACTIVE_BIT])
    else $error("completed descriptor still active");
  a_toggle_update: assert property (eng_rx_pkt && !eng_done.valid && !eng_wr
                     |=> mem_q[$past(hdr_addr) + 12'd1][HDR_TOGGLE_BIT] == $past(eng_rx_toggle))
    else $error("toggle bit not refreshed");
  a_result_code: assert property (eng_done.valid && !eng_wr
                     |=> mem_q[$past(hdr_addr) + 12'd1][7:4] == $past(eng_done.result_code))
    else $error("result code not written");
  a_ack_full_set: assert property (transfer_end_signal && port_wr && !acc_iso |=> ack_full_q)
    else $error("ack area not flagged full after write");
  a_sof_period: assert property (sof_q |=> !sof_q [*2])
    else $error("frame ticks too close");
  c_eot: cover property (transfer_end_signal && port_wr);
  c_list_end: cover property (eng_list_end && eng_list_done);
  c_opf_block: cover property (opf_used_q && eng_hdr_q.one_per_frame_bit && eng_issue_req);
endmodule : ptdu_buffer_core
`default_nettype wire

// ---- verification/ptdu_cpu_model.sv ----
// Processor model: AXI4-Lite master filling and reading the buffer RAM.
// Assumes the slave on aclk; every wait is bounded and raises tmo.
`timescale 1ns/1ns
`default_nettype none
module ptdu_cpu_model (
  input  wire logic        aclk,
  input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata,
  output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  output logic             tmo,
  output logic [11:0]      s_axi_awaddr, s_axi_araddr,
  output logic [31:0]      s_axi_wdata
);
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tmo} = '0;
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
  // Whole aligned words only, so headers and payloads stay four-byte aligned
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      // Released lines show the inverse so a stale value never passes
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    tmo <= 1'b1;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo <= 1'b1;
  endtask : rd
endmodule : ptdu_cpu_model
`default_nettype wire

// ---- verification/tb_ptdu_buffer_core.sv ----
// Self-checking bench: processor model on the register bus, bench acts as host engine.
// Assumes 10 MHz aclk and a shortened frame.
`timescale 1ns/1ns
`default_nettype none
module tb_ptdu_buffer_core
  import ptdu_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, eng_rx_pkt = 1'b0, eng_rx_toggle = 1'b0, tmo;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, eng_list_end, eng_issue_ok;
  logic sof_q, transfer_end_signal_q, irq, dma_req_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [11:0] s_axi_awaddr, s_axi_araddr, eng_desc_addr = 12'h000;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, w0, w1, s = 32'd74;
  logic [7:0] eng_rdata_q, eng_wdata = 8'h00;
  wire logic [AW-1:0] eng_addr = eng_desc_addr;
  wire logic [3:0] s_axi_wstrb = 4'hf;
  wire logic eng_area_iso = 1'b0, eng_wr = 1'b0, eng_list_done = 1'b0, eng_issue_req = 1'b0;
  ptdu_hdr_t eng_hdr_q, h;
  ptdu_done_t eng_done = '0, v;
  int miscompares = 0, comparisons = 0, ends = 0;
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (transfer_end_signal_q) ends++;
  ptdu_buffer_core #(.FRAME_CYCLES(20)) u_dut (.*);
  ptdu_cpu_model u_cpu (.*);
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  function automatic logic [11:0] ra(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ra
  function automatic ptdu_hdr_t done_hdr(input ptdu_hdr_t x, input ptdu_done_t c);
    {x.actual_bytes_hi, x.actual_bytes_lo} = c.actual_bytes;
    {x.result_code, x.active, x.toggle} = {c.result_code, 1'b0, c.toggle};
    return x;
  endfunction : done_hdr
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge tmo) begin
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(eng_hdr_q.one_per_frame_bit, 1'b0, "one per frame after reset");
    u_cpu.rd(ra(IDX_BUF_STAT), d, resp);
    chk(d, 32'h0, "status after reset");
    // Lengths that fill the RAM exactly: ack plus two iso halves
    w0 = rnd() & 32'h03fc;
    u_cpu.wr(ra(IDX_ISO_LEN), w0, resp);
    u_cpu.wr(ra(IDX_ACK_LEN), 32'h1000 - 2 * w0, resp);
    u_cpu.rd(ra(IDX_ISO_LEN), d, resp);
    chk(d, w0, "iso length");
    u_cpu.rd(ra(IDX_ACK_LEN), d, resp);
    chk(d, 32'h1000 - 2 * w0, "ack length");
    u_cpu.wr(ra(8'h30), rnd(), resp);
    chk(resp, RESP_SLVERR, "unmapped write");
    u_cpu.rd(ra(8'h30), d, resp);
    chk({d, resp}, {32'h0, RESP_SLVERR}, "unmapped read");
    // One header and one payload word in DMA mode, single bursts, into the ack area
    h = {rnd(), rnd()};
    {h.iso_format, h.token_direction} = {1'b0, (rnd() % 2 ? DIR_IN : DIR_OUT)};
    {h.max_packet_bytes_hi, h.max_packet_bytes_lo} = 10'h8;
    {h.total_byte_count_hi, h.total_byte_count_lo} = 10'h4;
    {w1, w0} = h;
    u_cpu.wr(ra(IDX_DMA_CFG), 32'h1, resp);
    u_cpu.wr(ra(IDX_XFER_CNT), 32'hc, resp);
    #1 chk(dma_req_q, 1'b1, "dma request armed");
    u_cpu.wr(ra(IDX_ACK_PORT), w0, resp);
    u_cpu.wr(ra(IDX_ACK_PORT), w1, resp);
    // IN reserves its payload space, OUT fills it
    w0 = (h.token_direction == DIR_IN) ? 32'h0 : rnd();
    u_cpu.wr(ra(IDX_ACK_PORT), w0, resp);
    u_cpu.rd(ra(IDX_IRQ_STAT), d, resp);
    chk(d[IRQ_EOT], 1'b1, "end of transfer");
    u_cpu.rd(ra(IDX_BUF_STAT), d, resp);
    chk(d[5:0], 6'h04, "ack full");
    chk(ends, 1, "one end pulse");
    chk(irq, 1'b0, "masked irq");
    u_cpu.wr(ra(IDX_IRQ_MASK), 32'h4, resp);
    chk(irq, 1'b1, "unmasked irq");
    u_cpu.wr(ra(IDX_IRQ_STAT), 32'h4, resp);
    chk(irq, 1'b0, "irq cleared");
    chk(eng_hdr_q, h, "header stored");
    chk(eng_list_end, h.list_end, "list end");
    // Engine completes the descriptor with a random code, then receives a packet
    d = rnd();
    v = {1'b1, d[3:0], d[4], d[14:5]};
    @(posedge aclk);
    {eng_done, eng_wdata} <= {v, d[23:16]};
    @(posedge aclk);
    eng_done <= '0;
    repeat (2) @(posedge aclk);
    #1;
    h = done_hdr(h, v);
    chk(eng_hdr_q, h, "completion rewrite");
    @(posedge aclk);
    {eng_rx_pkt, eng_rx_toggle} <= {1'b1, ~h.toggle};
    @(posedge aclk);
    eng_rx_pkt <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    h.toggle = ~h.toggle;
    chk(eng_hdr_q, h, "toggle refresh");
    chk(eng_rdata_q, h[7:0], "engine byte read");
    tally_and_finish();
  end
endmodule : tb_ptdu_buffer_core
`default_nettype wire
